// File: intc_top.sv
// interrupt recognition, prioritisation and dispatch with axi4-lite regs
// assumes source and cpu inputs are synchronous to CLK, events are pulses
//
// How it works
// - a peripheral source counts only while its flag and mask are both set.
// - recognised peripheral and request-pin sources wait for a clear global mask, nmi for its own bit.
// - several pending sources are taken one at a time by priority.
// - priority is fixed but software may promote one maskable source.
// - a recognised nmi beats every maskable source and is taken at once; trap, opcode, watchdog and clock monitor beat it.
// - entry saves the mask state and sets the global mask.
// - writing a one clears a flag; software can never set one.
// - return restores the saved mask state and re-arbitrates.
// - twenty distinct sources cover peripherals, pins, trap and opcode.
// - watchdog and clock monitor are reset-class with own vectors.
// - fixed vectors point into a table whose writes can be locked.
// - the request pin is edge latched after reset unless edge is cleared
// - reset sets the nmi mask bit; the nmi pin is level only.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
module intc_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  input wire intc_pkg::src_in_t SRC_IN,
  input wire intc_pkg::cpu_in_t CPU_IN,
  output logic INT_REQ,
  output logic [4:0] SRC_ID,
  output logic [15:0] VECTOR_ADDR,
  output logic [15:0] HANDLER_ADDR,
  output logic IN_SERVICE,
  output logic GLOBAL_MASK,
  output logic NMI_MASK,
  output logic RESET_REQ,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] byte_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic in_vec(input logic [7:0] a);
    return a >= intc_pkg::OFS_VEC_BASE && a < intc_pkg::OFS_VEC_END;
  endfunction

  function automatic logic [4:0] vec_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - intc_pkg::OFS_VEC_BASE;
    return d[6:2];
  endfunction

  // highest index wins; promoted source goes above all maskable ones
  function automatic logic [5:0] pick(input logic [19:0] p,
                                      input logic [4:0] pro);
    logic [5:0] r;
    logic [31:0] pw;
    r = 6'h00;
    pw = {12'h000, p};
    for (int k = 0; k < intc_pkg::NSRC; k++) begin
      if (p[k]) begin
        r = {1'b1, 5'(k)};
      end
    end
    if (pro < intc_pkg::PROMOTE_LIMIT && pw[pro] && p[19:15] == 5'h00) begin
      r = {1'b1, pro};
    end
    return r;
  endfunction

  function automatic logic [15:0] vec_ptr(input logic [4:0] idx);
    return intc_pkg::PSEUDO_BASE + 16'(idx) * intc_pkg::PSEUDO_STRIDE;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  intc_pkg::fsm_t fsm_r;
  logic [intc_pkg::NMASK-1:0] flag_r, mask_r, flag_clr;
  logic [4:0] promote_r, src_r;
  logic edge_r, prot_r, gmask_r, nmask_r;
  logic [6:0] boot_cnt_r;
  logic ext_req_q_r, ext_nmi_q_r, ext_latch_r;
  logic trap_pend_r, illop_pend_r, wdog_pend_r, clkmon_pend_r;
  logic [1:0] save_r [intc_pkg::SAVE_DEPTH];
  logic [1:0] depth_r;
  logic [intc_pkg::IST_W-1:0] istat_r, imask_r, ist_set;
  logic aw_hold_r, w_hold_r, rd_busy_r, rd_stage_r;
  logic [7:0] awaddr_r, araddr_r;
  logic [31:0] wdata_r, wm_r;
  logic [19:0] pend;
  logic [5:0] choice;
  logic wr_go, rd_go, take, is_nmi_class;
  logic [15:0] vec_rd;

  // ----------------------------------------------------------------
  // recognition and arbitration
  // ----------------------------------------------------------------
  logic ext_act;
  assign ext_act = edge_r ? ext_latch_r : ~ext_req_q_r;
  always_comb begin
    pend[13:0] = flag_r & mask_r & {intc_pkg::NMASK{~gmask_r}};
    pend[14] = ext_act & ~gmask_r;
    pend[15] = ~ext_nmi_q_r & ~nmask_r;
    pend[16] = trap_pend_r;
    pend[17] = illop_pend_r;
    pend[18] = wdog_pend_r;
    pend[19] = clkmon_pend_r;
  end

  assign choice = pick(pend, promote_r);
  assign take = choice[5] && depth_r < 2'(intc_pkg::SAVE_DEPTH)
                && (fsm_r == intc_pkg::ST_IDLE
                    || fsm_r == intc_pkg::ST_SERVICE);
  assign is_nmi_class = choice[4:0] == intc_pkg::IDX_EXT_NMI
                        || choice[4:0] >= intc_pkg::IDX_WATCHDOG_FAILURE;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  assign wr_go = aw_hold_r && w_hold_r && !S_AXI_BVALID;
  logic wr_flag, wr_mask, wr_ctrl, wr_imask, wr_prot, wr_vec;
  assign wr_flag = wr_go && awaddr_r == intc_pkg::OFS_FLAG;
  assign wr_mask = wr_go && awaddr_r == intc_pkg::OFS_MASK;
  assign wr_ctrl = wr_go && awaddr_r == intc_pkg::OFS_CTRL;
  assign wr_imask = wr_go && awaddr_r == intc_pkg::OFS_IMASK;
  assign wr_prot = wr_go && awaddr_r == intc_pkg::OFS_PROTECT;
  assign wr_vec = wr_go && in_vec(awaddr_r) && !prot_r;
  assign flag_clr = wr_flag ? (wdata_r[13:0] & wm_r[13:0]) : 14'h0000;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      flag_r <= 14'h0000;
    end else begin
      flag_r <= (flag_r & ~flag_clr) | SRC_IN.periph;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mask_r <= 14'h0000;
      promote_r <= intc_pkg::PROMOTE_NONE;
      imask_r <= 3'h0;
      prot_r <= intc_pkg::RST_PROTECT;
    end else begin
      if (wr_mask) begin
        mask_r <= (mask_r & ~wm_r[13:0]) | (wdata_r[13:0] & wm_r[13:0]);
      end
      if (wr_ctrl && wm_r[intc_pkg::CTRL_PRO_LSB]) begin
        promote_r <= wdata_r[intc_pkg::CTRL_PRO_MSB:intc_pkg::CTRL_PRO_LSB];
      end
      if (wr_imask && wm_r[0]) begin
        imask_r <= wdata_r[intc_pkg::IST_W-1:0];
      end
      if (wr_prot && wm_r[0]) begin
        prot_r <= wdata_r[0];
      end
    end
  end

  // edge select is writable only during the early window after reset
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      boot_cnt_r <= 7'd0;
      edge_r <= intc_pkg::RST_EDGE;
    end else begin
      if (boot_cnt_r < intc_pkg::PROTECT_CYCLES) begin
        boot_cnt_r <= boot_cnt_r + 7'd1;
      end
      if (wr_ctrl && wm_r[0] && boot_cnt_r < intc_pkg::PROTECT_CYCLES) begin
        edge_r <= wdata_r[intc_pkg::CTRL_EDGE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // pin sampling and event latches
  // ----------------------------------------------------------------
  logic take_ext, take_trap, take_illop, take_wdog, take_clk;
  assign take_ext = take && choice[4:0] == intc_pkg::IDX_EXT_REQ;
  assign take_trap = take && choice[4:0] == intc_pkg::IDX_SOFTWARE_TRAP;
  assign take_illop = take && choice[4:0] == intc_pkg::IDX_ILLEGAL_OP;
  assign take_wdog = take && choice[4:0] == intc_pkg::IDX_WATCHDOG_FAILURE;
  assign take_clk = take && choice[4:0] == intc_pkg::IDX_CLOCK_MONITOR;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ext_req_q_r <= 1'b1;
      ext_nmi_q_r <= 1'b1;
      ext_latch_r <= 1'b0;
      trap_pend_r <= 1'b0;
      illop_pend_r <= 1'b0;
      wdog_pend_r <= 1'b0;
      clkmon_pend_r <= 1'b0;
    end else begin
      ext_req_q_r <= SRC_IN.ext_req_n;
      ext_nmi_q_r <= SRC_IN.ext_nmi_n;
      ext_latch_r <= (ext_latch_r && !take_ext)
                     || (ext_req_q_r && !SRC_IN.ext_req_n);
      trap_pend_r <= (trap_pend_r && !take_trap)
                     || CPU_IN.software_trap;
      illop_pend_r <= (illop_pend_r && !take_illop)
                      || CPU_IN.illegal_op;
      wdog_pend_r <= (wdog_pend_r && !take_wdog)
                     || SRC_IN.watchdog_failure;
      clkmon_pend_r <= (clkmon_pend_r && !take_clk)
                       || SRC_IN.clock_monitor;
    end
  end

  // ----------------------------------------------------------------
  // dispatch sequence and mask bits
  // ----------------------------------------------------------------
  logic do_ret;
  logic [1:0] top_idx;
  assign do_ret = fsm_r == intc_pkg::ST_SERVICE
                  && CPU_IN.return_from_interrupt_instruction;
  assign top_idx = depth_r - 2'd1;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fsm_r <= intc_pkg::ST_IDLE;
      src_r <= 5'h00;
      depth_r <= 2'd0;
      save_r[0] <= 2'b00;
      save_r[1] <= 2'b00;
      gmask_r <= intc_pkg::RST_GMASK;
      nmask_r <= intc_pkg::RST_NMASK;
      INT_REQ <= 1'b0;
      VECTOR_ADDR <= intc_pkg::PSEUDO_BASE;
    end else begin
      if (wr_ctrl && wm_r[0]) begin
        gmask_r <= wdata_r[intc_pkg::CTRL_GMASK_BIT];
        if (!wdata_r[intc_pkg::CTRL_NMASK_BIT]) begin
          nmask_r <= 1'b0;
        end
      end
      unique case (fsm_r)
        intc_pkg::ST_IDLE, intc_pkg::ST_SERVICE: begin
          if (do_ret) begin
            {gmask_r, nmask_r} <= save_r[top_idx[0]];
            depth_r <= top_idx;
            if (depth_r == 2'd1) begin
              fsm_r <= intc_pkg::ST_IDLE;
            end
          end else if (take) begin
            fsm_r <= intc_pkg::ST_ENTRY;
            src_r <= choice[4:0];
            VECTOR_ADDR <= vec_ptr(choice[4:0]);
            INT_REQ <= 1'b1;
            save_r[depth_r[0]] <= {gmask_r, nmask_r};
            depth_r <= depth_r + 2'd1;
            gmask_r <= 1'b1;
            if (is_nmi_class) begin
              nmask_r <= 1'b1;
            end
          end
        end
        intc_pkg::ST_ENTRY: begin
          if (CPU_IN.save_done) begin
            fsm_r <= intc_pkg::ST_SERVICE;
            INT_REQ <= 1'b0;
          end
        end
        default: begin
          fsm_r <= intc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // handler table
  // ----------------------------------------------------------------
  vec_mem u_vec (
    .clk(CLK),
    .rst_n(RST_N),
    .we(wr_vec),
    .waddr(vec_idx(awaddr_r)),
    .wdata(wdata_r[15:0]),
    .wbe(wm_r[8] ? {1'b1, wm_r[0]} : {1'b0, wm_r[0]}),
    .raddr_a(take ? choice[4:0] : src_r),
    .rdata_a(HANDLER_ADDR),
    .raddr_b(vec_idx(araddr_r)),
    .rdata_b(vec_rd)
  );

  // ----------------------------------------------------------------
  // event status and interrupt line
  // ----------------------------------------------------------------
  logic rd_ist;
  assign ist_set = {take && is_nmi_class && choice[4],
                    do_ret, take};
  assign rd_ist = rd_go && araddr_r == intc_pkg::OFS_ISTAT;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      istat_r <= 3'h0;
      IRQ <= 1'b0;
      RESET_REQ <= 1'b0;
    end else begin
      istat_r <= (istat_r & ~(rd_ist ? istat_r : 3'h0)) | ist_set;
      IRQ <= |(istat_r & imask_r);
      RESET_REQ <= RESET_REQ || wdog_pend_r || clkmon_pend_r;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wm_r <= 32'h00000000;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= intc_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= {S_AXI_AWADDR[7:2], 2'b00};
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wm_r <= byte_mask(S_AXI_WSTRB);
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (awaddr_r <= intc_pkg::OFS_PROTECT
                        && awaddr_r != intc_pkg::OFS_STATE
                        && awaddr_r != intc_pkg::OFS_ISTAT)
                       || in_vec(awaddr_r)
                       ? intc_pkg::RESP_OKAY : intc_pkg::RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  assign rd_go = rd_busy_r && rd_stage_r;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rd_busy_r <= 1'b0;
      rd_stage_r <= 1'b0;
      araddr_r <= 8'h00;
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= intc_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        araddr_r <= {S_AXI_ARADDR[7:2], 2'b00};
        S_AXI_ARREADY <= 1'b0;
        rd_busy_r <= 1'b1;
        rd_stage_r <= 1'b0;
      end else if (rd_busy_r && !rd_stage_r) begin
        rd_stage_r <= 1'b1;
      end else if (rd_go) begin
        rd_busy_r <= 1'b0;
        rd_stage_r <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= intc_pkg::RESP_OKAY;
        S_AXI_RDATA <= 32'h00000000;
        if (in_vec(araddr_r)) begin
          S_AXI_RDATA <= {16'h0000, vec_rd};
        end else begin
          unique case (araddr_r)
            intc_pkg::OFS_FLAG: S_AXI_RDATA <= {18'h00000, flag_r};
            intc_pkg::OFS_MASK: S_AXI_RDATA <= {18'h00000, mask_r};
            intc_pkg::OFS_CTRL: S_AXI_RDATA <= {19'h00000, promote_r,
                                  5'h00, edge_r, nmask_r, gmask_r};
            intc_pkg::OFS_STATE: S_AXI_RDATA <= {15'h0000,
                                  fsm_r != intc_pkg::ST_IDLE, 2'b00,
                                  depth_r, 2'b00, fsm_r, 3'h0, src_r};
            intc_pkg::OFS_ISTAT: S_AXI_RDATA <= {29'h00000000, istat_r};
            intc_pkg::OFS_IMASK: S_AXI_RDATA <= {29'h00000000, imask_r};
            intc_pkg::OFS_PROTECT: S_AXI_RDATA <= {31'h00000000, prot_r};
            default: S_AXI_RRESP <= intc_pkg::RESP_SLVERR;
          endcase
        end
      end
      if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // cpu-facing status
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      SRC_ID <= 5'h00;
      IN_SERVICE <= 1'b0;
      GLOBAL_MASK <= intc_pkg::RST_GMASK;
      NMI_MASK <= intc_pkg::RST_NMASK;
    end else begin
      SRC_ID <= take ? choice[4:0] : src_r;
      IN_SERVICE <= take || (fsm_r != intc_pkg::ST_IDLE
                             && !(do_ret && depth_r == 2'd1));
      GLOBAL_MASK <= gmask_r;
      NMI_MASK <= nmask_r;
    end
  end

endmodule

// File: intc_pkg.sv
// constants, register map and carrier types of the interrupt prioritizer
// assumes a single 50 MHz clock and an axi4-lite register bus of 32 bits
package intc_pkg;

  // ----------------------------------------------------------------
  // sources
  // ----------------------------------------------------------------
  localparam int NSRC = 20;
  localparam int NMASK = 14;
  localparam logic [4:0] IDX_SERIAL_COMMS = 5'h00;
  localparam logic [4:0] IDX_SERIAL_PERIPH = 5'h01;
  localparam logic [4:0] IDX_PULSE_EDGE = 5'h02;
  localparam logic [4:0] IDX_PULSE_OVF = 5'h03;
  localparam logic [4:0] IDX_TIMER_OVF = 5'h04;
  localparam logic [4:0] IDX_CAP4_CMP5 = 5'h05;
  localparam logic [4:0] IDX_CMP4 = 5'h06;
  localparam logic [4:0] IDX_CMP3 = 5'h07;
  localparam logic [4:0] IDX_CMP2 = 5'h08;
  localparam logic [4:0] IDX_CMP1 = 5'h09;
  localparam logic [4:0] IDX_CAP3 = 5'h0a;
  localparam logic [4:0] IDX_CAP2 = 5'h0b;
  localparam logic [4:0] IDX_CAP1 = 5'h0c;
  localparam logic [4:0] IDX_TICK = 5'h0d;
  localparam logic [4:0] IDX_EXT_REQ = 5'h0e;
  localparam logic [4:0] IDX_EXT_NMI = 5'h0f;
  localparam logic [4:0] IDX_SOFTWARE_TRAP = 5'h10;
  localparam logic [4:0] IDX_ILLEGAL_OP = 5'h11;
  localparam logic [4:0] IDX_WATCHDOG_FAILURE = 5'h12;
  localparam logic [4:0] IDX_CLOCK_MONITOR = 5'h13;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_FLAG = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;
  localparam logic [7:0] OFS_ISTAT = 8'h10;
  localparam logic [7:0] OFS_IMASK = 8'h14;
  localparam logic [7:0] OFS_PROTECT = 8'h18;
  localparam logic [7:0] OFS_VEC_BASE = 8'h40;
  localparam logic [7:0] OFS_VEC_END = 8'h90;

  // control register fields
  localparam int CTRL_GMASK_BIT = 0;
  localparam int CTRL_NMASK_BIT = 1;
  localparam int CTRL_EDGE_BIT = 2;
  localparam int CTRL_PRO_LSB = 8;
  localparam int CTRL_PRO_MSB = 12;
  localparam logic [4:0] PROMOTE_NONE = 5'h1f;
  localparam logic [4:0] PROMOTE_LIMIT = 5'h0f;

  // state register fields
  localparam int STATE_SRC_LSB = 0;
  localparam int STATE_FSM_LSB = 8;
  localparam int STATE_DEPTH_LSB = 12;
  localparam int STATE_BUSY_BIT = 16;

  // interrupt status bits
  localparam int IST_W = 3;
  localparam int IST_ENTRY = 0;
  localparam int IST_RETURN = 1;
  localparam int IST_FAULT = 2;

  // reset values
  localparam logic RST_GMASK = 1'b1;
  localparam logic RST_NMASK = 1'b1;
  localparam logic RST_EDGE = 1'b1;
  localparam logic RST_PROTECT = 1'b1;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // timing and vectors
  // ----------------------------------------------------------------
  localparam logic [6:0] PROTECT_CYCLES = 7'd64;
  localparam int SAVE_DEPTH = 2;
  localparam logic [15:0] PSEUDO_BASE = 16'hae20;
  localparam logic [15:0] PSEUDO_LAST = 16'haebf;
  localparam logic [15:0] PSEUDO_STRIDE = 16'h0008;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ENTRY = 2'b01,
    ST_SERVICE = 2'b10
  } fsm_t;

  typedef struct packed {
    logic [NMASK-1:0] periph;
    logic ext_req_n;
    logic ext_nmi_n;
    logic watchdog_failure;
    logic clock_monitor;
  } src_in_t;

  typedef struct packed {
    logic save_done;
    logic return_from_interrupt_instruction;
    logic software_trap;
    logic illegal_op;
  } cpu_in_t;

endpackage

// File: vec_mem.sv
// modifiable handler table, one 16-bit word per source
// assumes writes are already filtered by the protect bit
`timescale 1ns/100ps
module vec_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [1:0] wbe,
  input wire logic [4:0] raddr_a,
  output logic [15:0] rdata_a,
  input wire logic [4:0] raddr_b,
  output logic [15:0] rdata_b
);

  logic [15:0] mem [intc_pkg::NSRC];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int k = 0; k < intc_pkg::NSRC; k++) begin
        mem[k] <= 16'h0000;
      end
    end else if (we && waddr < 5'(intc_pkg::NSRC)) begin
      if (wbe[0]) begin
        mem[waddr][7:0] <= wdata[7:0];
      end
      if (wbe[1]) begin
        mem[waddr][15:8] <= wdata[15:8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_a <= 16'h0000;
      rdata_b <= 16'h0000;
    end else begin
      rdata_a <= (raddr_a < 5'(intc_pkg::NSRC)) ? mem[raddr_a] : 16'h0000;
      rdata_b <= (raddr_b < 5'(intc_pkg::NSRC)) ? mem[raddr_b] : 16'h0000;
    end
  end

endmodule

// File: vec_mem_note_unused.sv
`timescale 1ns/100ps

// File: intc_monitor.sv
// checker of dispatch, masks and fault request of the prioritizer
// assumes it is bound onto intc_top
`timescale 1ns/100ps
module intc_monitor (
  input wire logic CLK,
  input wire logic RST_N,
  input wire intc_pkg::src_in_t SRC_IN,
  input wire intc_pkg::cpu_in_t CPU_IN,
  input wire logic INT_REQ,
  input wire logic [4:0] SRC_ID,
  input wire logic [15:0] VECTOR_ADDR,
  input wire logic GLOBAL_MASK,
  input wire logic NMI_MASK,
  input wire logic RESET_REQ
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  AST_VEC: assert property (INT_REQ |->
    VECTOR_ADDR == 16'hae20 + {8'h00, SRC_ID, 3'h0}) else $error("vector");
  AST_HOLD: assert property (INT_REQ && $past(INT_REQ) |->
    $stable(VECTOR_ADDR) && $stable(SRC_ID)) else $error("vector moved");
  AST_GMASK: assert property ($rose(INT_REQ) |=> GLOBAL_MASK)
    else $error("mask not set on entry");
  AST_MDISP: assert property ($rose(INT_REQ) && SRC_ID <= 5'h0e |->
    !GLOBAL_MASK) else $error("maskable taken while masked");
  AST_SAVE: assert property (INT_REQ && CPU_IN.save_done |=> !INT_REQ)
    else $error("request kept after save");
  AST_RST: assert property ($rose(RST_N) |-> NMI_MASK && GLOBAL_MASK)
    else $error("masks clear after reset");
  AST_WDOG: assert property (SRC_IN.watchdog_failure |->
    ##[1:3] RESET_REQ) else $error("no reset request");
  AST_RRST: assert property (RESET_REQ |=> RESET_REQ)
    else $error("reset request dropped");
  cover property ($rose(INT_REQ) && SRC_ID == 5'h0f);
  cover property ($rose(INT_REQ) && SRC_ID == 5'h02);
  cover property ($rose(RESET_REQ));
endmodule

// File: intc_cpu_model.sv
// cpu side: acknowledges entries, issues returns and traps
// assumes int_req comes from intc_top
`timescale 1ns/100ps
module intc_cpu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic int_req,
  input wire logic [2:0] lat,
  input wire logic ret,
  input wire logic [1:0] trap,
  output intc_pkg::cpu_in_t cpu
);
  // ----------------------------------------------------------------
  // state save after lat cycles
  // ----------------------------------------------------------------
  logic [2:0] cnt_r;
  always_ff @(posedge clk) begin
    if (!rst_n || !int_req) cnt_r <= 3'h0;
    else cnt_r <= cnt_r + 3'h1;
  end
  assign cpu = {int_req && cnt_r == lat, ret, trap};
endmodule

// File: tb.sv
// self-checking bench of intc_top
// assumes intc_monitor and intc_cpu_model beside it
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  logic arv = 1'b0, rry = 1'b0, ret = 1'b0;
  logic awr, wrd, bv, arr, rv, intr, gm, nm, rr;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, d;
  logic [1:0] br, rrsp, rsp, trap = 2'h0;
  logic [2:0] lat = 3'h0;
  logic [4:0] sid;
  logic [15:0] va, ha;
  logic ins, irq;
  logic [4:0] r_id[4] = '{5'h00, 5'h07, 5'h09, 5'h0d};
  logic [15:0] r_vec[4] = '{16'hae20, 16'hae58, 16'hae68, 16'hae88};
  intc_pkg::src_in_t src = {14'h0, 4'b1100};
  intc_pkg::cpu_in_t cpu;
  int fail_count = 0, n_compared = 0;
  always #10 clk = ~clk;
  intc_top i_dut (.CLK(clk), .RST_N(rst_n), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_BRESP(br),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_AXI_RDATA(rdat),
    .S_AXI_RRESP(rrsp), .SRC_IN(src), .CPU_IN(cpu), .INT_REQ(intr),
    .SRC_ID(sid), .VECTOR_ADDR(va), .HANDLER_ADDR(ha), .IN_SERVICE(ins),
    .GLOBAL_MASK(gm), .NMI_MASK(nm), .RESET_REQ(rr), .IRQ(irq));
  intc_cpu_model i_cpu (.clk(clk), .rst_n(rst_n), .int_req(intr),
    .lat(lat), .ret(ret), .trap(trap), .cpu(cpu));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input string nm_s, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h seen %h", nm_s, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] dv);
    @(posedge clk);
    awa <= a; wd <= dv; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    rsp = br; bry <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rdat; rsp = rrsp; rry <= 1'b0;
  endtask
  task pulse(input logic [13:0] p);
    @(posedge clk); src.periph <= p;
    @(posedge clk); src.periph <= 14'h0;
  endtask
  task svc(input logic [4:0] id, input logic [15:0] v);
    int k;
    k = 0;
    while (intr !== 1'b1 && k < 40) begin @(posedge clk); k++; end
    chk("src", {27'h0, sid}, {27'h0, id});
    chk("vec", {16'h0, va}, {16'h0, v});
    chk("hnd", {16'h0, ha}, {16'h0, id == 5'h07 ? 16'h1234 : 16'h0});
    chk("ins", {31'h0, ins}, 32'h1);
    while (intr === 1'b1 && k < 80) begin @(posedge clk); k++; end
    chk("gmask", {31'h0, gm}, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    src.ext_nmi_n <= 1'b1;
    if (id < 5'h0e) wr(8'h00, 32'h1 << id);
    @(posedge clk); ret <= 1'b1;
    @(posedge clk); ret <= 1'b0;
  endtask
  task tally_and_finish;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h08); chk("ctrl", d, 32'h1f07);
    rd(8'h30); chk("resp", {30'h0, rsp}, 32'h2);
    wr(8'h08, 32'h1f04); wr(8'h04, 32'h3fff);
    wr(8'h40, 32'h55); wr(8'h18, 32'h0); wr(8'h5c, 32'h1234);
    wr(8'h14, 32'h1);
    for (int i = 0; i < 4; i++) begin
      lat <= i[0] ? 3'h5 : 3'h0;
      pulse(14'h1 << r_id[i]);
      svc(r_id[i], r_vec[i]);
      repeat (2) @(posedge clk);
      chk("gm_ret", {31'h0, gm}, 32'h0);
    end
    rd(8'h10); chk("istat", d, 32'h3);
    @(posedge clk); chk("irq", {31'h0, irq}, 32'h0);
    wr(8'h04, 32'h0); pulse(14'h8); repeat (6) @(posedge clk);
    chk("req", {31'h0, intr}, 32'h0);
    rd(8'h00); chk("flag", d, 32'h8);
    wr(8'h00, 32'h0); rd(8'h00); chk("flag", d, 32'h8);
    wr(8'h00, 32'h8); wr(8'h04, 32'h3fff);
    rd(8'h00); chk("flag", d, 32'h0);
    wr(8'h0c, 32'h0); chk("bresp", {30'h0, rsp}, 32'h2);
    wr(8'h08, 32'h1f05); pulse(14'h0224); repeat (4) @(posedge clk);
    chk("held", {31'h0, intr}, 32'h0);
    wr(8'h08, 32'h0204);
    svc(5'h02, 16'hae30); svc(5'h09, 16'hae68); svc(5'h05, 16'hae48);
    wr(8'h08, 32'h1f05); pulse(14'h10);
    @(posedge clk); src.ext_nmi_n <= 1'b0;
    svc(5'h0f, 16'hae98); repeat (6) @(posedge clk);
    chk("held", {31'h0, intr}, 32'h0);
    wr(8'h00, 32'h10); wr(8'h08, 32'h1f04);
    @(posedge clk); src.ext_req_n <= 1'b0;
    @(posedge clk); src.ext_req_n <= 1'b1;
    svc(5'h0e, 16'hae90);
    for (int t = 0; t < 2; t++) begin
      @(posedge clk); trap <= t[0] ? 2'h1 : 2'h2;
      @(posedge clk); trap <= 2'h0;
      svc(t[0] ? 5'h11 : 5'h10, t[0] ? 16'haea8 : 16'haea0);
    end
    @(posedge clk); src.watchdog_failure <= 1'b1;
    @(posedge clk); src.watchdog_failure <= 1'b0;
    svc(5'h12, 16'haeb0);
    chk("rst_req", {31'h0, rr}, 32'h1);
    rst_n <= 1'b0; repeat (2) @(posedge clk); rst_n <= 1'b1;
    @(posedge clk); chk("rst_req", {31'h0, rr}, 32'h0);
    chk("nmask", {31'h0, nm}, 32'h1);
    tally_and_finish;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    tally_and_finish;
  end
endmodule
bind intc_top intc_monitor i_mon (.*);
